/* File: inc/pmha_map.svh */
// Purpose: constants of the port manager host access block
// Assumes: 40 MHz system clock, fast-mode serial link
// Notes: register indices are byte addresses on the serial link
// Function
// - source register read-only, follows live events
// - interrupt low when any unmasked source bit set
// - mask register gates sources from interrupt
// - address 01 plus five select pins
// - first written byte loads index register
// - index increments after every data byte
// - data bytes land at K, K+1, ...
// - write carries zero to 255 data bytes
// - writes to missing registers are dropped
// - bytes travel most significant bit first
// - read starts at current index value
// - read returns zero to 255 consecutive bytes
// - nine parallel pins: index plus five flags
// - channel index advances every 60 clocks
// - power good for powered normal channel
// - overload for powered channel over class
// - overcurrent when channel hits current limit
// - disconnect when powered channel loses signature
// - probing for unpowered channel under detection
// - flags enabled by config bit, reset high
// - foreign address ignored until next start
// - acknowledge matched address and received bytes
// - start or stop mid-byte discards it
`ifndef PMHA_MAP_SVH
`define PMHA_MAP_SVH

// device address and register map
`define PMHA_ADDR_HI 2'h1
`define PMHA_RA_IRQ 8'h00
`define PMHA_RA_IRQ_MASK 8'h01
`define PMHA_RA_GCFG2 8'h02
`define PMHA_RA_CH_BASE 8'h10
`define PMHA_IRQ_MASK_RST 8'h0F
`define PMHA_GCFG2_RST 8'h01
`define PMHA_GCFG2_FLAG_EN 0

// parallel monitor
`define PMHA_NUM_CHAN 12
`define PMHA_LAST_CHAN 4'hB
`define PMHA_CHAN_CYC 6'h3C

// host timing
`define PMHA_CLK_PERIOD_NS 25
`define PMHA_SCL_PERIOD_NS 2500
`define PMHA_QTR_CYC ((`PMHA_SCL_PERIOD_NS + 4 * `PMHA_CLK_PERIOD_NS - 1) / (4 * `PMHA_CLK_PERIOD_NS))

// host register map and commands
`define PMHA_HR_CTRL 3'h0
`define PMHA_HR_TXDATA 3'h1
`define PMHA_HR_RXDATA 3'h2
`define PMHA_HR_STATUS 3'h3
`define PMHA_CMD_START 3'h1
`define PMHA_CMD_STOP 3'h2
`define PMHA_CMD_WRITE 3'h3
`define PMHA_CMD_READ_ACK 3'h4
`define PMHA_CMD_READ_NACK 3'h5

`endif

/* File: inc/pmha_pkg.sv */
// Purpose: shared types of the host access block
// Assumes: constants come from pmha_map.svh
// Notes: types only
package pmha_pkg;
  typedef logic [7:0] pmha_byte_t;
  typedef enum logic [2:0] {
    DS_IDLE, DS_ADDR, DS_ADDR_ACK, DS_RX, DS_RX_ACK, DS_TX, DS_TX_ACK
  } pmha_dev_state_e;
  typedef enum logic [1:0] {
    HS_IDLE, HS_START, HS_BIT, HS_STOP
  } pmha_host_state_e;
endpackage

/* File: inc/pmha_if.sv */
// Purpose: open-drain serial link between host and device
// Assumes: pull-ups on both lines
// Notes: an enable low means that party pulls toward its output value
`timescale 1ns/100ps
`default_nettype none
interface pmha_if;
  logic scl_oe_n_host;
  logic scl_o_host;
  logic sda_oe_n_host;
  logic sda_o_host;
  logic sda_oe_n_dev;
  logic sda_o_dev;
  logic scl;
  logic sda;
  // wired-and resolution with pull-up
  assign scl = scl_oe_n_host | scl_o_host;
  assign sda = (sda_oe_n_host | sda_o_host) & (sda_oe_n_dev | sda_o_dev);
  modport dev (input scl, input sda, output sda_oe_n_dev, output sda_o_dev);
  modport host (input scl, input sda, output scl_oe_n_host, output scl_o_host,
                output sda_oe_n_host, output sda_o_host);
endinterface
`default_nettype wire

/* File: src/pmha_dev.sv */
// Purpose: serial slave, register file, interrupt and parallel monitor
// Assumes: channel status inputs come from logic on i_clk
// Notes: no clock stretching; link lines sampled by i_clk
`include "pmha_map.svh"
`timescale 1ns/100ps
`default_nettype none
module pmha_dev
  import pmha_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // serial link
  pmha_if.dev bus,
  // address select pins
  input wire logic [4:0] i_addr_sel,
  // per-channel status from the power logic
  input wire logic [11:0] i_ch_powered,
  input wire logic [11:0] i_ch_over_class,
  input wire logic [11:0] i_ch_over_current,
  input wire logic [11:0] i_ch_mps_lost,
  input wire logic [11:0] i_ch_probing,
  // interrupt
  output logic o_interrupt_out_low,
  // parallel monitor
  output logic [3:0] o_channel_index_out,
  output logic o_power_good_flag,
  output logic o_overload_flag,
  output logic o_overcurrent_flag,
  output logic o_disconnect_flag,
  output logic o_probing_flag
);

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [4:0] asel_sync0_q;
  logic [4:0] asel_sync1_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  pmha_dev_state_e state_q;
  logic [3:0] cnt_q;
  pmha_byte_t shift_q;
  pmha_byte_t index_q;
  logic rw_q;
  logic first_q;
  logic sda_oe_n_q;
  logic byte_done;
  logic load_tx;
  logic wr_en;
  pmha_byte_t tx_byte;
  pmha_byte_t irq_mask_q;
  pmha_byte_t gcfg2_q;
  logic [3:0] irq_src;
  logic [5:0] div_q;
  logic [3:0] chan_q;

  // per-channel status code: {probing, disconnect, overcurrent, overload, power good}
  function automatic logic [4:0] ch_status(input logic [3:0] ch);
    logic p;
    p = i_ch_powered[ch];
    ch_status = {~p & i_ch_probing[ch],
                 p & i_ch_mps_lost[ch],
                 i_ch_over_current[ch],
                 p & i_ch_over_class[ch],
                 p & ~i_ch_over_class[ch] & ~i_ch_over_current[ch] & ~i_ch_mps_lost[ch]};
  endfunction

  // register read decode; unmapped locations read zero
  function automatic pmha_byte_t reg_read(input pmha_byte_t a);
    pmha_byte_t r;
    r = 8'h00;
    if (a == `PMHA_RA_IRQ) begin
      r = {4'h0, irq_src};
    end else if (a == `PMHA_RA_IRQ_MASK) begin
      r = irq_mask_q;
    end else if (a == `PMHA_RA_GCFG2) begin
      r = gcfg2_q;
    end else if (a >= `PMHA_RA_CH_BASE && a < `PMHA_RA_CH_BASE + 8'(`PMHA_NUM_CHAN)) begin
      r = {3'h0, ch_status(4'(a - `PMHA_RA_CH_BASE))};
    end
    return r;
  endfunction

  // two-stage synchronisers on link and address pins
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // pins sampled continuously, reset clears both stages
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      asel_sync0_q <= 5'h00;
      asel_sync1_q <= 5'h00;
    end else begin
      asel_sync0_q <= i_addr_sel;
      asel_sync1_q <= asel_sync0_q;
    end
  end

  // line events; start and stop need scl high on both samples
  assign scl_rise = scl_sync_q[1] & ~scl_prev_q;
  assign scl_fall = ~scl_sync_q[1] & scl_prev_q;
  assign start_c = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
  assign stop_c = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
  assign byte_done = scl_fall && (cnt_q == 4'h8);
  always_comb tx_byte = reg_read(index_q);
  assign load_tx = scl_fall && ((state_q == DS_ADDR_ACK && rw_q) || state_q == DS_TX_ACK);
  assign wr_en = (state_q == DS_RX) && byte_done && !first_q && !start_c && !stop_c;

  // slave protocol engine
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= DS_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      index_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (start_c) begin
      state_q <= DS_ADDR;
      cnt_q <= 4'h0;
      sda_oe_n_q <= 1'b1;
    end else if (stop_c) begin
      state_q <= DS_IDLE;
      sda_oe_n_q <= 1'b1;
    end else if (load_tx) begin
      // fetch next byte and advance index on the same edge
      shift_q <= tx_byte;
      index_q <= index_q + 8'h01;
      sda_oe_n_q <= tx_byte[7];
      cnt_q <= 4'h0;
      state_q <= DS_TX;
    end else begin
      unique case (state_q)
        DS_IDLE: begin
          sda_oe_n_q <= 1'b1;
        end
        DS_ADDR: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_sync_q[1]};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            if (shift_q[7:1] == {`PMHA_ADDR_HI, asel_sync1_q}) begin
              sda_oe_n_q <= 1'b0;
              rw_q <= shift_q[0];
              state_q <= DS_ADDR_ACK;
            end else begin
              state_q <= DS_IDLE;
            end
          end
        end
        DS_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_n_q <= 1'b1;
            first_q <= 1'b1;
            cnt_q <= 4'h0;
            state_q <= DS_RX;
          end
        end
        DS_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_sync_q[1]};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            sda_oe_n_q <= 1'b0;
            state_q <= DS_RX_ACK;
            if (first_q) begin
              index_q <= shift_q;
            end else begin
              index_q <= index_q + 8'h01;
            end
          end
        end
        DS_RX_ACK: begin
          // any byte count is fine; only stop or start ends it
          if (scl_fall) begin
            sda_oe_n_q <= 1'b1;
            first_q <= 1'b0;
            cnt_q <= 4'h0;
            state_q <= DS_RX;
          end
        end
        DS_TX: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            sda_oe_n_q <= 1'b1;
            state_q <= DS_TX_ACK;
          end else if (scl_fall) begin
            shift_q <= {shift_q[6:0], 1'b0};
            sda_oe_n_q <= shift_q[6];
          end
        end
        DS_TX_ACK: begin
          // master nack ends the read; next byte only after ack
          if (scl_rise && sda_sync_q[1]) begin
            state_q <= DS_IDLE;
          end
        end
      endcase
    end
  end

  // writable registers; irq source and channel status are read-only
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_mask_q <= `PMHA_IRQ_MASK_RST;
      gcfg2_q <= `PMHA_GCFG2_RST;
    end else if (wr_en) begin
      if (index_q == `PMHA_RA_IRQ_MASK) begin
        irq_mask_q <= shift_q;
      end else if (index_q == `PMHA_RA_GCFG2) begin
        gcfg2_q <= shift_q;
      end
      // other locations drop the byte silently
    end
  end
  // is the missing else above: no storage, transaction continues

  // sources follow live conditions, so they clear only when the event goes
  assign irq_src = {|(~i_ch_powered & i_ch_probing),
                    |(i_ch_powered & i_ch_mps_lost),
                    |i_ch_over_current,
                    |(i_ch_powered & i_ch_over_class)};

  // registered interrupt pin
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_interrupt_out_low <= 1'b1;
    end else begin
      o_interrupt_out_low <= ~|(irq_src & irq_mask_q[3:0]);
    end
  end

  // channel scan divider and index
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_q <= 6'h00;
      chan_q <= 4'h0;
    end else if (div_q == `PMHA_CHAN_CYC - 6'h01) begin
      div_q <= 6'h00;
      chan_q <= (chan_q == `PMHA_LAST_CHAN) ? 4'h0 : chan_q + 4'h1;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // flag pins follow indexed channel, forced low when disabled
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_channel_index_out <= 4'h0;
      {o_probing_flag, o_disconnect_flag, o_overcurrent_flag, o_overload_flag, o_power_good_flag} <= 5'h00;
    end else begin
      o_channel_index_out <= chan_q;
      {o_probing_flag, o_disconnect_flag, o_overcurrent_flag, o_overload_flag, o_power_good_flag} <=
        gcfg2_q[`PMHA_GCFG2_FLAG_EN] ? ch_status(chan_q) : 5'h00;
    end
  end

  // open-drain data line: only ever pulls low
  assign bus.sda_oe_n_dev = sda_oe_n_q;
  assign bus.sda_o_dev = 1'b0;

endmodule
`default_nettype wire

/* File: src/pmha_host.sv */
// Purpose: serial link master driven by byte-level commands
// Assumes: slave never stretches the clock
// Notes: software sequences start, bytes and stop itself
`include "pmha_map.svh"
`timescale 1ns/100ps
`default_nettype none
module pmha_host
  import pmha_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // serial link
  pmha_if.host bus,
  // register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata
);

  localparam logic [6:0] QTR_CYC = 7'(`PMHA_QTR_CYC);

  logic [1:0] sda_sync_q;
  pmha_host_state_e state_q;
  logic [6:0] qcnt_q;
  logic [1:0] phase_q;
  logic [3:0] bitn_q;
  logic [8:0] out_q;
  logic [8:0] in_q;
  pmha_byte_t txdata_q;
  pmha_byte_t rxdata_q;
  logic nack_q;
  logic scl_oe_n_q;
  logic sda_oe_n_q;
  logic tick;
  logic cmd;

  // data line synchroniser
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sda_sync_q <= 2'h3;
    end else begin
      sda_sync_q <= {sda_sync_q[0], bus.sda};
    end
  end

  assign cmd = i_wr && (i_addr == `PMHA_HR_CTRL) && (state_q == HS_IDLE);
  assign tick = (qcnt_q == QTR_CYC - 7'h01);

  // quarter-bit divider, restarted by each command
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || cmd || tick) begin
      qcnt_q <= 7'h00;
    end else begin
      qcnt_q <= qcnt_q + 7'h01;
    end
  end

  // transmit data register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      txdata_q <= 8'h00;
    end else if (i_wr && i_addr == `PMHA_HR_TXDATA) begin
      txdata_q <= i_wdata;
    end
  end

  // line sequencer: four quarter phases per bit
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= HS_IDLE;
      phase_q <= 2'h0;
      bitn_q <= 4'h0;
      out_q <= 9'h1FF;
      in_q <= 9'h000;
      rxdata_q <= 8'h00;
      nack_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else if (cmd) begin
      phase_q <= 2'h0;
      bitn_q <= 4'h0;
      unique case (i_wdata[2:0])
        `PMHA_CMD_START: state_q <= HS_START;
        `PMHA_CMD_STOP: state_q <= HS_STOP;
        `PMHA_CMD_WRITE: begin
          out_q <= {txdata_q, 1'b1};
          state_q <= HS_BIT;
        end
        `PMHA_CMD_READ_ACK: begin
          out_q <= {8'hFF, 1'b0};
          state_q <= HS_BIT;
        end
        `PMHA_CMD_READ_NACK: begin
          out_q <= {8'hFF, 1'b1};
          state_q <= HS_BIT;
        end
        default: state_q <= HS_IDLE;
      endcase
    end else if (tick) begin
      phase_q <= phase_q + 2'h1;
      unique case (state_q)
        HS_IDLE: phase_q <= 2'h0;
        HS_START: begin
          // release both lines first so a repeated start works too
          unique case (phase_q)
            2'h0: sda_oe_n_q <= 1'b1;
            2'h1: scl_oe_n_q <= 1'b1;
            2'h2: sda_oe_n_q <= 1'b0;
            2'h3: begin
              scl_oe_n_q <= 1'b0;
              state_q <= HS_IDLE;
            end
          endcase
        end
        HS_STOP: begin
          unique case (phase_q)
            2'h0: sda_oe_n_q <= 1'b0;
            2'h1: scl_oe_n_q <= 1'b1;
            2'h2: sda_oe_n_q <= 1'b1;
            2'h3: state_q <= HS_IDLE;
          endcase
        end
        HS_BIT: begin
          unique case (phase_q)
            2'h0: sda_oe_n_q <= out_q[8];
            2'h1: scl_oe_n_q <= 1'b1;
            2'h2: in_q <= {in_q[7:0], sda_sync_q[1]};
            2'h3: begin
              scl_oe_n_q <= 1'b0;
              out_q <= {out_q[7:0], 1'b1};
              bitn_q <= bitn_q + 4'h1;
              if (bitn_q == 4'h8) begin
                rxdata_q <= in_q[8:1];
                nack_q <= in_q[0];
                state_q <= HS_IDLE;
              end
            end
          endcase
        end
      endcase
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        `PMHA_HR_TXDATA: o_rdata <= txdata_q;
        `PMHA_HR_RXDATA: o_rdata <= rxdata_q;
        `PMHA_HR_STATUS: o_rdata <= {6'h00, nack_q, state_q != HS_IDLE};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // open-drain drivers
  assign bus.scl_oe_n_host = scl_oe_n_q;
  assign bus.scl_o_host = 1'b0;
  assign bus.sda_oe_n_host = sda_oe_n_q;
  assign bus.sda_o_host = 1'b0;

endmodule
`default_nettype wire

/* File: bench/pmha_properties.sv */
// Purpose: link and monitor properties of the host access pair
// Assumes: one clock domain, sync active-low reset
// Notes: index period and scl low time kept in helper counters
`timescale 1ns/100ps
`default_nettype none
module pmha_properties (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // link lines
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_n_host,
  input wire logic sda_oe_n_dev,
  // channel status inputs
  input wire logic [11:0] i_ch_powered,
  input wire logic [11:0] i_ch_over_class,
  input wire logic [11:0] i_ch_over_current,
  input wire logic [11:0] i_ch_mps_lost,
  input wire logic [11:0] i_ch_probing,
  // device outputs
  input wire logic o_interrupt_out_low,
  input wire logic [3:0] o_channel_index_out,
  input wire logic o_power_good_flag,
  input wire logic o_overload_flag,
  input wire logic o_overcurrent_flag,
  input wire logic o_disconnect_flag,
  input wire logic o_probing_flag
);
  logic [3:0] idx_q;
  logic [6:0] cnt_q;
  logic seen_q;
  logic [3:0] low_q;
  logic moved;
  logic src_any;
  assign moved = o_channel_index_out != idx_q;
  assign src_any = |(i_ch_powered & i_ch_over_class) | (|i_ch_over_current) |
    (|(i_ch_powered & i_ch_mps_lost)) | (|(~i_ch_powered & i_ch_probing));
  // cycles since the last index step; a stuck divider shows as a count past 60
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      idx_q <= 4'h0;
      cnt_q <= 7'h00;
      seen_q <= 1'b0;
    end else begin
      idx_q <= o_channel_index_out;
      cnt_q <= moved ? 7'h01 : cnt_q + 7'h01;
      seen_q <= seen_q | moved;
    end
  end
  // cycles since scl went low, saturating
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || scl) begin
      low_q <= 4'h0;
    end else if (low_q != 4'hF) begin
      low_q <= low_q + 4'h1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_no_src;
    !src_any [*2];
  endsequence
  sequence s_soon_after_fall;
    !scl && low_q >= 4'h1 && low_q <= 4'h8;
  endsequence
  property p_idx_step;
    moved |-> o_channel_index_out == ((idx_q == 4'hB) ? 4'h0 : idx_q + 4'h1);
  endproperty
  property p_idx_period;
    moved && seen_q |-> cnt_q == 7'h3C;
  endproperty
  property p_idx_late;
    seen_q |-> cnt_q <= 7'h3C;
  endproperty
  property p_int_idle;
    s_no_src |=> o_interrupt_out_low;
  endproperty
  property p_int_cause;
    $fell(o_interrupt_out_low) |-> $past(src_any);
  endproperty
  property p_pgood_excl;
    o_power_good_flag |-> !(o_overload_flag || o_overcurrent_flag || o_disconnect_flag || o_probing_flag);
  endproperty
  property p_probe_excl;
    o_probing_flag |-> !(o_overload_flag || o_disconnect_flag);
  endproperty
  property p_sda_hold;
    scl && $past(scl) && $stable(sda_oe_n_host) |-> $stable(sda);
  endproperty
  property p_dev_edge;
    $changed(sda_oe_n_dev) |-> s_soon_after_fall;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("channel index step wrong");
  a_idx_period: assert property (p_idx_period) else $error("channel index period wrong");
  a_idx_late: assert property (p_idx_late) else $error("channel index stalled");
  a_int_idle: assert property (p_int_idle) else $error("interrupt low without source");
  a_int_cause: assert property (p_int_cause) else $error("interrupt fell without source");
  a_pgood_excl: assert property (p_pgood_excl) else $error("power good beside fault");
  a_probe_excl: assert property (p_probe_excl) else $error("probing on powered channel");
  a_sda_hold: assert property (p_sda_hold) else $error("data moved while clock high");
  a_dev_edge: assert property (p_dev_edge) else $error("device data change off clock fall");
endmodule
`default_nettype wire

/* File: bench/tb_port_manager_host_access.sv */
// Purpose: end-to-end bench of host and device over the serial link
// Assumes: host commands polled until idle
// Notes: channel inputs held still during each transfer
`include "pmha_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_port_manager_host_access;
  import pmha_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [4:0] sel = 5'h00;
  logic [11:0] pw = 12'h000;
  logic [11:0] ocl = 12'h000;
  logic [11:0] ocu = 12'h000;
  logic [11:0] mps = 12'h000;
  logic [11:0] prb = 12'h000;
  logic [2:0] h_addr = 3'h0;
  logic [7:0] h_wdata = 8'h00;
  logic h_wr = 1'b0;
  logic h_rd = 1'b0;
  wire [7:0] h_rdata;
  wire irq_n;
  wire [3:0] idx;
  wire [4:0] fl;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  pmha_if lnk();
  pmha_host i_pmha_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(lnk), .i_addr(h_addr),
    .i_wdata(h_wdata), .i_wr(h_wr), .i_rd(h_rd), .o_rdata(h_rdata));
  pmha_dev i_pmha_dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(lnk), .i_addr_sel(sel),
    .i_ch_powered(pw), .i_ch_over_class(ocl), .i_ch_over_current(ocu), .i_ch_mps_lost(mps),
    .i_ch_probing(prb), .o_interrupt_out_low(irq_n), .o_channel_index_out(idx),
    .o_power_good_flag(fl[4]), .o_overload_flag(fl[3]), .o_overcurrent_flag(fl[2]),
    .o_disconnect_flag(fl[1]), .o_probing_flag(fl[0]));
  pmha_properties i_pmha_properties (.i_clk(i_clk), .i_rst_n(i_rst_n), .scl(lnk.scl),
    .sda(lnk.sda), .sda_oe_n_host(lnk.sda_oe_n_host), .sda_oe_n_dev(lnk.sda_oe_n_dev),
    .i_ch_powered(pw), .i_ch_over_class(ocl), .i_ch_over_current(ocu), .i_ch_mps_lost(mps),
    .i_ch_probing(prb), .o_interrupt_out_low(irq_n), .o_channel_index_out(idx),
    .o_power_good_flag(fl[4]), .o_overload_flag(fl[3]), .o_overcurrent_flag(fl[2]),
    .o_disconnect_flag(fl[1]), .o_probing_flag(fl[0]));
  // 40 MHz clock
  always #12.5 i_clk = ~i_clk;
  // expected flags {good, overload, overcurrent, disconnect, probing}
  function automatic logic [4:0] exp_fl(input logic [3:0] c);
    exp_fl = {pw[c] & ~ocl[c] & ~ocu[c] & ~mps[c], pw[c] & ocl[c], ocu[c], pw[c] & mps[c], ~pw[c] & prb[c]};
  endfunction
  // expected sources {probing, disconnect, overcurrent, overload} over all channels
  function automatic logic [3:0] exp_src();
    logic [4:0] f;
    exp_src = 4'h0;
    for (int c = 0; c < 12; c++) begin
      f = exp_fl(4'(c));
      exp_src = exp_src | {f[0], f[1], f[2], f[3]};
    end
  endfunction
  task automatic finish_test();
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic hw(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    h_addr <= a;
    h_wdata <= d;
    h_wr <= 1'b1;
    @(posedge i_clk);
    h_wr <= 1'b0;
  endtask
  task automatic hr(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    h_addr <= a;
    h_rd <= 1'b1;
    @(posedge i_clk);
    h_rd <= 1'b0;
    #1 d = h_rdata;
  endtask
  // issue a command and poll until the host is idle again
  task automatic cmd(input logic [2:0] c);
    logic [7:0] st;
    hw(`PMHA_HR_CTRL, {5'h00, c});
    repeat (2) @(posedge i_clk);
    for (int n = 0; n < 2000; n++) begin
      hr(`PMHA_HR_STATUS, st);
      if (st[0] === 1'b0) break;
    end
  endtask
  task automatic wbyte(input logic [7:0] b, output logic nk);
    logic [7:0] st;
    hw(`PMHA_HR_TXDATA, b);
    cmd(`PMHA_CMD_WRITE);
    hr(`PMHA_HR_STATUS, st);
    nk = st[1];
  endtask
  task automatic open(input logic rw);
    logic nk;
    cmd(`PMHA_CMD_START);
    wbyte({2'h1, sel, rw}, nk);
    chk_bit(nk, 1'b0);
  endtask
  task automatic dev_wr(input logic [7:0] ra, input logic [7:0] dq[$]);
    logic nk;
    open(1'b0);
    wbyte(ra, nk);
    chk_bit(nk, 1'b0);
    foreach (dq[i]) begin
      wbyte(dq[i], nk);
      chk_bit(nk, 1'b0);
    end
    cmd(`PMHA_CMD_STOP);
  endtask
  task automatic dev_rd(input int n, output logic [7:0] q[$]);
    logic [7:0] d;
    q = {};
    open(1'b1);
    for (int i = 0; i < n; i++) begin
      cmd(i == n - 1 ? `PMHA_CMD_READ_NACK : `PMHA_CMD_READ_ACK);
      hr(`PMHA_HR_RXDATA, d);
      q.push_back(d);
    end
    cmd(`PMHA_CMD_STOP);
  endtask
  task automatic rnd_ch(input logic zero);
    @(posedge i_clk);
    pw <= zero ? 12'h000 : 12'($urandom);
    ocl <= zero ? 12'h000 : 12'($urandom);
    ocu <= zero ? 12'h000 : 12'($urandom) & 12'($urandom);
    mps <= zero ? 12'h000 : 12'($urandom);
    prb <= zero ? 12'h000 : 12'($urandom);
  endtask
  // wait for the next index step, then compare the flags shown
  task automatic chk_mon();
    logic [3:0] was;
    was = idx;
    for (int n = 0; n < 100 && idx === was; n++) @(posedge i_clk);
    repeat (2) @(posedge i_clk);
    #1 chk_byte({3'h0, fl}, {3'h0, exp_fl(idx)});
  endtask
  // hang guard, well above the roughly 54000 cycles of the run
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 70000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    logic [7:0] rq[$];
    logic [7:0] nq[$];
    logic [7:0] m;
    logic nk;
    void'($urandom(32'hDFD61E6B));
    sel <= 5'($urandom);
    rnd_ch(1'b0);
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    // reset values read from index zero without an address byte
    dev_rd(3, rq);
    chk_byte(rq[0], {4'h0, exp_src()});
    chk_byte(rq[1], `PMHA_IRQ_MASK_RST);
    chk_byte(rq[2], `PMHA_GCFG2_RST);
    // burst into mask, config and a missing register
    m = {4'h0, 4'($urandom)};
    dev_wr(`PMHA_RA_IRQ_MASK, '{m, 8'h00, 8'hA5});
    dev_rd(1, rq);
    chk_byte(rq[0], 8'h00);
    dev_wr(`PMHA_RA_IRQ_MASK, nq);
    // live channel events, so the disabled flags and the mask have something to hide
    rnd_ch(1'b0);
    dev_rd(3, rq);
    chk_byte(rq[0], m);
    chk_byte(rq[1], 8'h00);
    chk_byte(rq[2], 8'h00);
    chk_bit(irq_n, ~|(exp_src() & m[3:0]));
    chk_byte({3'h0, fl}, 8'h00);
    // mask, events and monitor sweep; first all masked, last all quiet
    for (int k = 0; k < 4; k++) begin
      m = (k == 0) ? 8'h00 : {4'h0, 4'($urandom)};
      dev_wr(`PMHA_RA_IRQ_MASK, '{m, 8'h01});
      rnd_ch(k == 3);
      repeat (3) @(posedge i_clk);
      #1 chk_bit(irq_n, ~|(exp_src() & m[3:0]));
      // source register tracks live events; the quiet round shows it cleared
      if (k > 1) begin
        dev_wr(`PMHA_RA_IRQ, nq);
        dev_rd(1, rq);
        chk_byte(rq[0], {4'h0, exp_src()});
      end
      repeat (13) chk_mon();
    end
    // foreign addresses: lowest select bit flipped, then upper bits wrong
    for (int k = 0; k < 2; k++) begin
      cmd(`PMHA_CMD_START);
      wbyte(k ? {2'h2, sel, 1'b0} : {2'h1, sel ^ 5'h01, 1'b0}, nk);
      chk_bit(nk, 1'b1);
      // bytes after a foreign address must not reach the config register
      wbyte(`PMHA_RA_GCFG2, nk);
      wbyte(8'h00, nk);
      chk_bit(nk, 1'b1);
      cmd(`PMHA_CMD_STOP);
    end
    dev_wr(`PMHA_RA_GCFG2, nq);
    dev_rd(1, rq);
    chk_byte(rq[0], 8'h01);
    finish_test();
  end
endmodule
`default_nettype wire
